// [logic/ppi_pixel_port.sv]
// module: pixel port capture, priority decode and serializer
// *****************************************************************
// What this block does
// - capture color words on latch strobe rise
// - accept four 24-bit lanes, 96 lines
// - support 24/16/15 direct, 8-bit pseudo formats
// - capture controls with color data same edge
// - pipeline on pixel clock, any strobe phase
// - generate strobe output at required frequency
// - blank and sync force blank/sync levels
// - per-color enable bits encode sync
// - all enables off ignores sync encoding
// - active-low digital sync with pipeline delay
// - tri-level enable and low input, tri level on enabled colors
// - two-bit field selects priority function
// - demux priority inputs in lane order
// - 8:1 pseudo reuses blue as priority
// - palette select mismatch forces zero current
// - bypass control picks palette/bypass/overlay one
// - bypass switching only on supporting variant
// - overlay nonzero shows overlay color
// - mux rate from two-bit control field
// *****************************************************************
`default_nettype none
module ppi_pixel_port
  import ppi_pkg::*;
#(
  parameter bit HAS_BYPASS = 1'b1
)(
  input  wire logic               clock,
  input  wire logic               resetn,
  input  wire logic               pixel_latch_strobe_in,
  input  wire logic [CDATA_W-1:0] color_in,
  input  wire logic               sync_n_in,
  input  wire logic               blank_n_in,
  input  wire logic               three_level_timing_in,
  input  wire logic [3:0]         priority_sel_bit0,
  input  wire logic [3:0]         priority_sel_bit1,
  output logic                    latch_strobe_source,
  output logic                    separate_digital_timing_pin,
  output ppi_pix_t                pix_out,
  output logic                    pix_valid,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);

  // *****************************************************************
  // functions
  // *****************************************************************
  function automatic logic [3:0] mux_count(input ppi_mux_t m);
    case (m)
      MUX_8:   mux_count = 4'h8;
      MUX_4:   mux_count = 4'h4;
      default: mux_count = 4'h2;
    endcase
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (s[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    wmerge = r;
  endfunction

  // *****************************************************************
  // register bus
  // *****************************************************************
  logic [31:0] ctrl_reg;
  logic [7:0]  awaddr_reg;
  logic        aw_have_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        w_have_reg;
  logic [15:0] latch_cnt_reg;
  logic [3:0]  tap_reg;

  wire ppi_mux_t mux_sel    = ppi_mux_t'(ctrl_reg[F_MUX_LO +: 2]);
  wire ppi_pri_t pri_sel    = ppi_pri_t'(ctrl_reg[F_PRI_LO +: 2]);
  wire [1:0]     match_code = ctrl_reg[F_MATCH_LO +: 2];
  wire           green_timing_encode_en = ctrl_reg[F_GREN];
  wire           red_timing_encode_en   = ctrl_reg[F_RDEN];
  wire           blue_timing_encode_en  = ctrl_reg[F_BLEN];
  wire           three_level_enable_bit = ctrl_reg[F_TRIEN];
  wire ppi_bpp_t bpp_sel    = ppi_bpp_t'(ctrl_reg[F_BPP_LO +: 2]);

  wire do_write   = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire wr_ctrl    = do_write && (awaddr_reg == ADDR_CTRL);
  wire wr_known   = (awaddr_reg == ADDR_CTRL) ||
                    (awaddr_reg == ADDR_STATUS) ||
                    (awaddr_reg == ADDR_LATCH);
  wire rd_known   = (s_axi_araddr == ADDR_CTRL) ||
                    (s_axi_araddr == ADDR_STATUS) ||
                    (s_axi_araddr == ADDR_LATCH);
  wire rd_take    = s_axi_arvalid && s_axi_arready;

  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire [31:0] status_word = {24'h00_0000, tap_reg, 2'h0,
                             mux_sel};
  wire [31:0] rd_word =
    (s_axi_araddr == ADDR_CTRL)   ? ctrl_reg :
    (s_axi_araddr == ADDR_STATUS) ? status_word :
    (s_axi_araddr == ADDR_LATCH)  ? {16'h0000, latch_cnt_reg} :
                                    32'h0000_0000;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      ctrl_reg    <= CTRL_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_ctrl)
        ctrl_reg <= wmerge(ctrl_reg, wdata_reg, wstrb_reg);
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // *****************************************************************
  // strobe output divider
  // *****************************************************************
  logic [3:0] div_reg;
  wire  [3:0] div_max = mux_count(mux_sel);
  wire        div_wrap = (div_reg >= div_max - 4'h1);

  // strobe out at clock over mux
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      div_reg             <= 4'h0;
      latch_strobe_source <= 1'b0;
    end
    else
    begin
      div_reg             <= div_wrap ? 4'h0 : div_reg + 4'h1;
      latch_strobe_source <= (div_reg < (div_max >> 1));
    end
  end

  // *****************************************************************
  // strobe synchroniser and capture
  // *****************************************************************
  logic         lsi_s1_reg;
  logic         lsi_s2_reg;
  logic         lsi_s3_reg;
  logic [CDATA_W-1:0] cd_s1_reg;
  logic [CDATA_W-1:0] cd_s2_reg;
  ppi_ctl_t     ct_s1_reg;
  ppi_ctl_t     ct_s2_reg;
  logic [CDATA_W-1:0] cap_data_reg;
  ppi_ctl_t     cap_ctl_reg;

  wire ppi_ctl_t ct_pins = '{sync_n:  sync_n_in,
                             blank_n: blank_n_in,
                             tri_n:   three_level_timing_in,
                             ps0:     {4'h0, priority_sel_bit0},
                             ps1:     {4'h0, priority_sel_bit1}};
  // edge found on pixel clock, any phase
  wire strobe_rise = lsi_s2_reg && !lsi_s3_reg;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      lsi_s1_reg <= 1'b0;
      lsi_s2_reg <= 1'b0;
      lsi_s3_reg <= 1'b0;
      cd_s1_reg  <= '0;
      cd_s2_reg  <= '0;
      ct_s1_reg  <= '0;
      ct_s2_reg  <= '0;
    end
    else
    begin
      lsi_s1_reg <= pixel_latch_strobe_in;
      lsi_s2_reg <= lsi_s1_reg;
      lsi_s3_reg <= lsi_s2_reg;
      cd_s1_reg  <= color_in;
      cd_s2_reg  <= cd_s1_reg;
      ct_s1_reg  <= ct_pins;
      ct_s2_reg  <= ct_s1_reg;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cap_data_reg  <= '0;
      cap_ctl_reg   <= '0;
      latch_cnt_reg <= 16'h0000;
    end
    else if (strobe_rise)
    begin
      cap_data_reg  <= cd_s2_reg;
      cap_ctl_reg   <= ct_s2_reg;
      latch_cnt_reg <= latch_cnt_reg + 16'h0001;
    end
  end

  // *****************************************************************
  // serializer
  // *****************************************************************
  logic [3:0] tap_next;
  logic       run_reg;

  // first lane first, one per clock
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      tap_reg <= 4'h0;
      run_reg <= 1'b0;
    end
    else if (strobe_rise)
    begin
      tap_reg <= 4'h0;
      run_reg <= 1'b1;
    end
    else if (run_reg)
    begin
      tap_reg <= tap_next;
      run_reg <= (tap_next != 4'h0);
    end
  end
  assign tap_next = (tap_reg >= div_max - 4'h1) ? 4'h0 : tap_reg + 4'h1;

  // pixel extraction per format
  // 8-bit pseudo at 8:1 takes red and green bytes of each lane;
  // other rates take only the low byte of one lane per pixel
  wire [1:0] lane_idx = (mux_sel == MUX_8) ? tap_reg[2:1] :
                        (mux_sel == MUX_4) ? tap_reg[1:0] :
                                             {tap_reg[0], 1'b0};
  wire [LANE_W-1:0] lane = cap_data_reg[lane_idx*LANE_W +: LANE_W];
  wire pseudo8 = (bpp_sel == BPP_8);
  wire [7:0] pseudo_b = (mux_sel == MUX_8) ?
                        (tap_reg[0] ? lane[15:8] : lane[7:0]) :
                        lane[7:0];
  wire [PIX_W-1:0] pix_data =
    pseudo8            ? {pseudo_b, pseudo_b, pseudo_b} :
    (bpp_sel == BPP_16)? {lane[15:11], 3'h0, lane[10:5], 2'h0,
                          lane[4:0], 3'h0} :
    (bpp_sel == BPP_15)? {lane[14:10], 3'h0, lane[9:5], 3'h0,
                          lane[4:0], 3'h0} :
                         lane;

  // blue bytes carry priority at 8:1
  wire use_blue = pseudo8 && (mux_sel == MUX_8);
  wire [7:0] blue_b = lane[23:16];
  wire pbit0 = use_blue ? blue_b[{tap_reg[0], 2'h0}] :
               cap_ctl_reg.ps0[lane_idx];
  wire pbit1 = use_blue ? blue_b[{tap_reg[0], 2'h1}] :
               cap_ctl_reg.ps1[lane_idx];
  wire [1:0] prio = {pbit1, pbit0};

  // *****************************************************************
  // priority function and level decode
  // *****************************************************************
  // priority function select
  wire byp_ok = HAS_BYPASS && !use_blue;
  wire off = (pri_sel == PRI_PALSEL) && (prio != match_code);
  wire ppi_src_t src =
    (pri_sel == PRI_OVERLAY && prio != 2'h0) ? SRC_OVERLAY :
    (pri_sel == PRI_BYPASS && byp_ok && pbit0) ? SRC_OVERLAY :
    (pri_sel == PRI_BYPASS && byp_ok && pbit1) ? SRC_BYPASS :
                                                  SRC_PALETTE;
  wire [1:0] ovl = (pri_sel == PRI_OVERLAY) ? prio :
                   (src == SRC_OVERLAY) ? 2'h1 : 2'h0;

  wire sync_on = !cap_ctl_reg.sync_n;
  wire tri_on  = three_level_enable_bit && !cap_ctl_reg.tri_n;
  function automatic ppi_lvl_t lvl(input logic en);
    if (off)
      lvl = LVL_OFF;
    else if (en && sync_on)
      lvl = LVL_SYNC;
    else if (en && tri_on)
      lvl = LVL_TRI;
    else if (!cap_ctl_reg.blank_n)
      lvl = LVL_BLANK;
    else
      lvl = LVL_VIDEO;
  endfunction

  wire ppi_pix_t pix_next = '{data:    pix_data,
                              src:     src,
                              overlay: ovl,
                              lvl_r:   lvl(red_timing_encode_en),
                              lvl_g:   lvl(green_timing_encode_en),
                              lvl_b:   lvl(blue_timing_encode_en)};

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      pix_out   <= '0;
      pix_valid <= 1'b0;
      separate_digital_timing_pin <= 1'b1;
    end
    else
    begin
      pix_out   <= pix_next;
      pix_valid <= run_reg;
      separate_digital_timing_pin <= run_reg ? cap_ctl_reg.sync_n
                                             : 1'b1;
    end
  end

endmodule
`default_nettype wire

// [logic/ppi_pkg.sv]
// package: constants and types for the pixel port input control block
`default_nettype none
package ppi_pkg;
  localparam int LANES        = 4;
  localparam int LANE_W       = 24;
  localparam int CDATA_W      = LANES * LANE_W;
  localparam int PIX_W        = 24;
  localparam int PS_W         = 8;

  // axi4-lite register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LATCH  = 8'h08;

  // control register field positions
  localparam int F_MUX_LO   = 0;
  localparam int F_PRI_LO   = 2;
  localparam int F_MATCH_LO = 4;
  localparam int F_GREN     = 6;
  localparam int F_RDEN     = 7;
  localparam int F_BLEN     = 8;
  localparam int F_TRIEN    = 9;
  localparam int F_PAL_LO   = 12;
  localparam int F_BYP_LO   = 16;
  localparam int F_BPP_LO   = 20;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MUX_8 = 2'h0,
    MUX_4 = 2'h1,
    MUX_2 = 2'h2
  } ppi_mux_t;

  typedef enum logic [1:0] {
    PRI_PALSEL = 2'h0,
    PRI_BYPASS = 2'h1,
    PRI_OVERLAY= 2'h2,
    PRI_IGNORE = 2'h3
  } ppi_pri_t;

  // pixel format: 24, 16, 15 bit direct or 8 bit pseudo-color
  typedef enum logic [1:0] {
    BPP_24 = 2'h0,
    BPP_16 = 2'h1,
    BPP_15 = 2'h2,
    BPP_8  = 2'h3
  } ppi_bpp_t;

  // output level selector for the analog stage
  typedef enum logic [2:0] {
    LVL_VIDEO = 3'h0,
    LVL_BLANK = 3'h1,
    LVL_SYNC  = 3'h2,
    LVL_TRI   = 3'h3,
    LVL_OFF   = 3'h4
  } ppi_lvl_t;

  typedef enum logic [1:0] {
    SRC_PALETTE = 2'h0,
    SRC_BYPASS  = 2'h1,
    SRC_OVERLAY = 2'h2
  } ppi_src_t;

  typedef struct packed {
    logic            sync_n;
    logic            blank_n;
    logic            tri_n;
    logic [PS_W-1:0] ps0;
    logic [PS_W-1:0] ps1;
  } ppi_ctl_t;

  typedef struct packed {
    logic [PIX_W-1:0] data;
    ppi_src_t         src;
    logic [1:0]       overlay;
    ppi_lvl_t         lvl_r;
    ppi_lvl_t         lvl_g;
    ppi_lvl_t         lvl_b;
  } ppi_pix_t;
endpackage
`default_nettype wire

// [verification/ppi_fb_model.sv]
// model: frame buffer sending one latch event per go pulse
`default_nettype none
module ppi_fb_model
  import ppi_pkg::*;
(
  input  wire logic [CDATA_W-1:0] next_color,
  input  wire ppi_ctl_t           next_ctl,
  input  wire logic               go,
  output logic                    strobe,
  output logic [CDATA_W-1:0]      color,
  output ppi_ctl_t                ctl
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    strobe = 1'b0;
    color = '0;
    ctl = '1;
  end
  // data around edge
  // strobe idles low, so each event is well below the mux rate
  always @(posedge go)
  begin
    color = next_color;
    ctl = next_ctl;
    #62.5 strobe = 1'b1;
    #62.5 strobe = 1'b0;
    // hold over: lines no longer show the word
    color = ~color;
    ctl = ~ctl;
  end
endmodule
`default_nettype wire

// [verification/ppi_pixel_port_monitor.sv]
// checker: port properties of the pixel port block
`default_nettype none
module ppi_pixel_port_monitor
  import ppi_pkg::*;
(
  input wire logic     clock,
  input wire logic     resetn,
  input wire logic     latch_strobe_source,
  input wire logic     separate_digital_timing_pin,
  input wire ppi_pix_t pix_out,
  input wire logic     pix_valid,
  input wire logic     s_axi_awvalid,
  input wire logic     s_axi_awready,
  input wire logic     s_axi_wvalid,
  input wire logic     s_axi_wready,
  input wire logic     s_axi_bvalid,
  input wire logic     s_axi_arvalid,
  input wire logic     s_axi_arready,
  input wire logic     s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // ****
  // steps
  // ****
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_burst;
    $rose(pix_valid);
  endsequence
  a_strobe_runs: assert property (
    $rose(latch_strobe_source) |-> ##[2:8] $rose(latch_strobe_source))
    else $error("strobe out period out of range");
  a_burst_len: assert property (
    s_burst |-> pix_valid[*2])
    else $error("pixel burst shorter than two");
  a_off_all: assert property (
    pix_valid && pix_out.lvl_g == LVL_OFF |->
      pix_out.lvl_r == LVL_OFF && pix_out.lvl_b == LVL_OFF)
    else $error("outputs not shut together");
  a_blank_all: assert property (
    pix_valid && pix_out.lvl_g == LVL_BLANK |->
      pix_out.lvl_r inside {LVL_BLANK, LVL_SYNC, LVL_TRI} &&
      pix_out.lvl_b inside {LVL_BLANK, LVL_SYNC, LVL_TRI})
    else $error("blank not on every output");
  a_sync_pin: assert property (
    pix_valid && pix_out.lvl_g == LVL_SYNC |-> !separate_digital_timing_pin)
    else $error("sync pin not aligned with video");
  a_ovl_code: assert property (
    pix_valid && pix_out.src == SRC_OVERLAY |-> pix_out.overlay != 2'h0)
    else $error("overlay shown for code zero");
  // both halves are held one cycle before the response is raised
  a_write_answer: assert property (
    s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule
bind ppi_pixel_port ppi_pixel_port_monitor mon (
  .clock, .resetn, .latch_strobe_source, .separate_digital_timing_pin,
  .pix_out, .pix_valid, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid
);
`default_nettype wire

// [verification/ppi_pixel_port_tb.sv]
// testbench: register access and pixel events through the port
`default_nettype none
module ppi_pixel_port_tb;
  import ppi_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic               clock = 1'b0;
  logic               resetn = 1'b0;
  logic [CDATA_W-1:0] nc = '0;
  ppi_ctl_t           nk = '1;
  logic               go = 1'b0;
  logic               stb, lso, spin, pv, awr, wr, bv, arr, rv;
  logic [CDATA_W-1:0] col;
  ppi_ctl_t           ctl;
  ppi_pix_t           px;
  ppi_pix_t           got [8];
  logic               gsp [8];
  logic [7:0]         awa = '0, ara = '0;
  logic               awv = 1'b0, wv = 1'b0, bre = 1'b0;
  logic               arv = 1'b0, rre = 1'b0;
  logic [31:0]        wd = '0, rd;
  logic [1:0]         br, rr;
  int                 num_errors = 0, samples_checked = 0, cyc = 0, n;

  ppi_pixel_port uut (
    .clock, .resetn, .pixel_latch_strobe_in(stb), .color_in(col),
    .sync_n_in(ctl.sync_n), .blank_n_in(ctl.blank_n),
    .three_level_timing_in(ctl.tri_n), .priority_sel_bit0(ctl.ps0[3:0]),
    .priority_sel_bit1(ctl.ps1[3:0]), .latch_strobe_source(lso),
    .separate_digital_timing_pin(spin), .pix_out(px), .pix_valid(pv),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rre)
  );
  ppi_fb_model fb (.next_color(nc), .next_ctl(nk), .go(go), .strobe(stb),
    .color(col), .ctl(ctl));

  always #5 clock = ~clock;
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      num_errors++;
      conclude();
    end
  end
  // ****
  // tasks
  // ****
  task automatic cmp_reg(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp_pix(string nm, logic [23:0] e, logic [23:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic axw(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge clock);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge clock);
      ta = awv && awr;
      tw = wv && wr;
      tb = bv;
      r = br;
      @(posedge clock);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    bre <= 1'b0;
  endtask
  task automatic axr(logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic ta, tr;
    @(posedge clock);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge clock);
      ta = arv && arr;
      tr = rv;
      d = rd;
      r = rr;
      @(posedge clock);
      if (ta) arv <= 1'b0;
    end
    rre <= 1'b0;
  endtask
  task automatic frame(logic [CDATA_W-1:0] c, ppi_ctl_t k);
    int w;
    @(posedge clock);
    nc <= c;
    nk <= k;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    w = 0;
    n = 0;
    while (!pv && w < 40)
    begin
      @(negedge clock);
      w++;
    end
    while (pv)
    begin
      got[n[2:0]] = px;
      gsp[n[2:0]] = spin;
      n++;
      @(negedge clock);
    end
  endtask
  task automatic per(output int p);
    p = 0;
    while (lso) @(negedge clock);
    while (!lso) @(negedge clock);
    while (lso) begin @(negedge clock); p++; end
    while (!lso) begin @(negedge clock); p++; end
  endtask
  function automatic logic [31:0] cv(int m, int p, int mt, int en, int b);
    return 32'(m << F_MUX_LO | p << F_PRI_LO | mt << F_MATCH_LO
      | en << F_GREN | b << F_BPP_LO);
  endfunction
  task automatic conclude();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****
  // sequence
  // ****
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    int p;
    ppi_ctl_t k;
    logic [CDATA_W-1:0] c;
    int cnt [3] = '{8, 4, 2};
    logic [3:0] en [5] = '{4'h1, 4'h0, 4'h0, 4'h9, 4'h6};
    logic [23:0] fx [2] = '{24'h084058, 24'h108058};
    logic [2:0] sg [5] = '{3'h3, 3'h3, 3'h5, 3'h6, 3'h3};
    ppi_lvl_t eg [5] = '{LVL_SYNC, LVL_VIDEO, LVL_BLANK, LVL_TRI, LVL_VIDEO};
    ppi_lvl_t er [5] = '{LVL_VIDEO, LVL_VIDEO, LVL_BLANK, LVL_VIDEO, LVL_SYNC};
    logic [4:0] pt [4][4] = '{'{5'h04, 5'h04, 5'h00, 5'h04},
      '{5'h00, 5'h10, 5'h08, 5'h10}, '{5'h00, 5'h10, 5'h10, 5'h10},
      '{5'h00, 5'h00, 5'h00, 5'h00}};
    c = {24'h3C3D3E, 24'h2B2C2D, 24'h1A1B1C, 24'h090A0B};
    k = {3'h7, 8'h00, 8'h00};
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    axr(ADDR_CTRL, d, r);
    cmp_reg("ctrl reset", CTRL_RESET, d);
    axw(8'h0C, 32'hFFFFFFFF, r);
    cmp_reg("unmapped write", 32'(RESP_SLVERR), 32'(r));
    axr(8'h0C, d, r);
    cmp_reg("unmapped read", 32'(RESP_SLVERR), 32'(r));
    for (int m = 0; m < 3; m++)
    begin
      axw(ADDR_CTRL, cv(m, 0, 0, 0, m == 0 ? 3 : 0), r);
      frame(c, k);
      cmp_pix("pixel count", 24'(cnt[m]), 24'(n));
      per(p);
      cmp_pix("strobe period", 24'(cnt[m]), 24'(p));
      if (m == 2) cmp_pix("lane two", c[71:48], got[1].data);
      if (m == 0)
      begin
        cmp_pix("blue prio off", 24'(LVL_OFF), 24'(got[0].lvl_g));
        cmp_pix("blue prio on", 24'(LVL_VIDEO), 24'(got[1].lvl_g));
      end
      for (int i = 0; i < 4 && m == 1; i++)
        cmp_pix("lane data", c[24*i +: 24], got[i].data);
    end
    // 16 and 15 bit words sit msb-aligned in each color byte
    for (int b = 1; b < 3; b++)
    begin
      axw(ADDR_CTRL, cv(1, 0, 0, 0, b), r);
      frame(c, k);
      cmp_pix("packed pixel", fx[b-1], got[0].data);
    end
    for (int i = 0; i < 5; i++)
    begin
      axw(ADDR_CTRL, cv(1, 0, 0, en[i], 0), r);
      {k.sync_n, k.blank_n, k.tri_n} = sg[i];
      frame(c, k);
      cmp_pix("green level", 24'(eg[i]), 24'(got[0].lvl_g));
      cmp_pix("red level", 24'(er[i]), 24'(got[3].lvl_r));
      cmp_pix("blue level", 24'(er[i]), 24'(got[1].lvl_b));
      cmp_pix("sync pin", 24'(sg[i][2]), 24'(gsp[0]));
    end
    k = {3'h7, 8'h0A, 8'h0C};
    for (int q = 0; q < 4; q++)
    begin
      axw(ADDR_CTRL, cv(1, q, 2, 0, 0), r);
      frame(c, k);
      for (int i = 0; i < 4; i++)
      begin
        cmp_pix("src level", 24'(pt[q][i]),
          24'({got[i].src, got[i].lvl_g}));
        if (pt[q][i][4])
          cmp_pix("overlay", q == 1 ? 24'h1 : 24'(i),
            24'(got[i].overlay));
      end
    end
    axr(ADDR_CTRL, d, r);
    cmp_reg("ctrl readback", cv(1, 3, 2, 0, 0), d);
    conclude();
  end
endmodule
`default_nettype wire
